// ===== core/afr_pkg.sv
// Constants, types and field layout for the amplifier fault-recovery and PDM option registers.
// ============================================================================
// Overview of operation
// - Warning status reads bit0 warning, rest zero.
// - Warning active cuts gain by selected step.
// - Auto retries limited 1/3/7/unlimited, resets unlimited.
// - Writing trigger one makes one manual attempt.
// - Bit2 picks undervoltage auto or manual recovery.
// - Bit1 picks overheat auto or manual recovery.
// - Bit0 picks overcurrent auto or manual recovery.
// - Fault control register resets to 0x30.
// - Select pin high: bit7 picks PDM channel.
// - Select pin low: bit6 enables pattern control.
// - Bit4 clear in PDM: answer only 0x34.
// - Bit4 set in PDM, select pin low: address from pin.
// - Bits3:2 choose normal or low-latency path.
// - Bit1 shares amplifier input bitclock with sense.
// - Bit0 in PDM picks output voltage or battery sense.
// - PDM option register resets to 0x40.
// - Boost fault has own mode bit, shares the fault control trigger.
// - Fault flags read one while fault present.
package afr_pkg;

	// ========================================================================
	// Register offsets and reset values
	localparam logic [7:0] ADDR_FAULT_STATUS = 8'h10;
	localparam logic [7:0] ADDR_WARN_STATUS  = 8'h11;
	localparam logic [7:0] ADDR_RETRY_CTRL   = 8'h12;
	localparam logic [7:0] ADDR_PDM_OPT      = 8'h13;
	localparam logic [7:0] ADDR_BOOST_CTRL   = 8'h16;
	localparam logic [7:0] RST_RETRY_CTRL    = 8'h30;
	localparam logic [7:0] RST_PDM_OPT       = 8'h40;
	localparam logic [7:0] RST_BOOST_CTRL    = 8'h00;
	localparam logic [7:0] FC_WRITE_MASK     = 8'hF7;
	localparam logic [7:0] READ_ZERO         = 8'h00;

	// ========================================================================
	// Field positions
	localparam int FC_GAIN_LSB    = 6;
	localparam int FC_LIMIT_LSB   = 4;
	localparam int FC_TRIG_BIT    = 3;
	localparam int FC_UV_BIT      = 2;
	localparam int FC_OT_BIT      = 1;
	localparam int FC_OC_BIT      = 0;
	localparam int PDM_CHAN_BIT   = 7;
	localparam int PDM_PAT_BIT    = 6;
	localparam int PDM_ADDR_BIT   = 4;
	localparam int PDM_LAT_LSB    = 2;
	localparam int PDM_SHARE_BIT  = 1;
	localparam int PDM_VBAT_BIT   = 0;
	localparam int BST_MODE_BIT   = 3;
	localparam int ST_BOOST_BIT   = 7;
	localparam int ST_UV_BIT      = 3;
	localparam int ST_OC_BIT      = 2;
	localparam int ST_OT_BIT      = 1;
	localparam int WARN_BIT       = 0;

	// ========================================================================
	// Retry limits and control-bus addresses
	localparam logic [1:0] LIMIT_ONE       = 2'h0;
	localparam logic [1:0] LIMIT_THREE     = 2'h1;
	localparam logic [1:0] LIMIT_SEVEN     = 2'h2;
	localparam logic [1:0] LIMIT_UNLIMITED = 2'h3;
	localparam logic [2:0] ATTEMPTS_ONE    = 3'h1;
	localparam logic [2:0] ATTEMPTS_THREE  = 3'h3;
	localparam logic [2:0] ATTEMPTS_SEVEN  = 3'h7;
	localparam logic [6:0] BUS_ADDR_FIXED  = 7'h34;
	localparam logic [6:0] BUS_ADDR_ALT    = 7'h35;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

	// ========================================================================
	// Timing of automatic retries
	localparam int CLK_MHZ       = 125;
	localparam int RETRY_GAP_US  = 10000;
	localparam int RETRY_GAP_CYC = RETRY_GAP_US * CLK_MHZ;
	localparam int GAP_W         = 21;
	localparam int NUM_FAULTS    = 4;

	// ========================================================================
	// Types
	typedef struct packed {
		logic boost;
		logic undervolt;
		logic overcurrent;
		logic overheat;
	} afr_fault_t;

	typedef struct packed {
		logic       channel_pick;
		logic       pattern_command_enable;
		logic [1:0] latency_mode;
		logic       shared_bitclock;
		logic       sense_battery;
	} afr_pdm_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_AACK  = 3'b010,
		ST_REG   = 3'b011,
		ST_DACK  = 3'b100,
		ST_WDATA = 3'b101,
		ST_RDATA = 3'b110,
		ST_RACK  = 3'b111
	} afr_bus_state_t;

endpackage

// ===== core/afr_regs.sv
// Fault-recovery and PDM option register bank with its control-bus slave.
`timescale 1ns/1ns
module afr_regs #(
	parameter int RETRY_GAP = afr_pkg::RETRY_GAP_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_drive_b,
	input  wire logic                  pdm_mode_pin,
	input  wire logic                  if_select_pin,
	input  wire logic                  channel_address_pin,
	input  wire logic                  overheat_warn_in,
	input  wire afr_pkg::afr_fault_t   fault_in,
	output afr_pkg::afr_fault_t        retry_pulse,
	output logic [1:0]                 warning_gain_cut,
	output afr_pkg::afr_pdm_cfg_t      pdm_cfg
);
	import afr_pkg::*;

	// ========================================================================
	// Declarations
	logic                 scl_s;
	logic                 sda_s;
	logic                 pdm_mode_s;
	logic                 if_sel_s;
	logic                 chan_pin_s;
	logic                 warn_s;
	afr_fault_t           fault_s;
	logic                 scl_prev_ff;
	logic                 sda_prev_ff;
	logic                 bus_start;
	logic                 bus_stop;
	logic                 scl_rise;
	logic                 scl_fall;
	afr_bus_state_t       state_ff;
	logic [3:0]           bit_cnt_ff;
	logic [7:0]           shreg_ff;
	logic [7:0]           ptr_ff;
	logic                 read_ff;
	logic                 wr_en_ff;
	logic [7:0]           wr_addr_ff;
	logic [7:0]           wr_data_ff;
	logic [7:0]           rd_data;
	logic [6:0]           dev_addr;
	logic [7:0]           retry_ctrl_ff;
	logic [7:0]           pdm_opt_ff;
	logic [7:0]           boost_ctrl_ff;
	logic                 manual_trig_ff;
	afr_fault_t           manual_mode;
	logic [2:0]           attempt_ff [NUM_FAULTS];
	logic [GAP_W-1:0]     gap_ff     [NUM_FAULTS];
	afr_fault_t           nxt_retry;

	// ========================================================================
	// Pin synchronisers
	afr_sync #(
		.W       (10),
		.RST_VAL (10'h300)
	) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     ({scl_in, sda_in, pdm_mode_pin, if_select_pin, channel_address_pin,
		         overheat_warn_in, fault_in}),
		.q     ({scl_s, sda_s, pdm_mode_s, if_sel_s, chan_pin_s, warn_s, fault_s})
	);

	// ========================================================================
	// Bus condition detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_prev_ff <= scl_s;
			sda_prev_ff <= sda_s;
		end
	end

	assign bus_start = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
	assign bus_stop  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
	assign scl_rise  = scl_s & ~scl_prev_ff;
	assign scl_fall  = ~scl_s & scl_prev_ff;

	// ========================================================================
	// Device address selection
	always_comb begin
		dev_addr = BUS_ADDR_FIXED;
		if (pdm_mode_s && !if_sel_s && pdm_opt_ff[PDM_ADDR_BIT]) begin
			dev_addr = chan_pin_s ? BUS_ADDR_ALT : BUS_ADDR_FIXED;
		end
	end

	// ========================================================================
	// Register read mux
	always_comb begin
		unique case (ptr_ff)
			ADDR_FAULT_STATUS: begin
				rd_data               = READ_ZERO;
				rd_data[ST_BOOST_BIT] = fault_s.boost;
				rd_data[ST_UV_BIT]    = fault_s.undervolt;
				rd_data[ST_OC_BIT]    = fault_s.overcurrent;
				rd_data[ST_OT_BIT]    = fault_s.overheat;
			end
			ADDR_WARN_STATUS: begin
				rd_data           = READ_ZERO;
				rd_data[WARN_BIT] = warn_s;
			end
			ADDR_RETRY_CTRL: rd_data = retry_ctrl_ff;
			ADDR_PDM_OPT:    rd_data = pdm_opt_ff;
			ADDR_BOOST_CTRL: rd_data = boost_ctrl_ff;
			default:         rd_data = READ_ZERO;
		endcase
	end

	// ========================================================================
	// Control-bus slave
	// Data changes only after a falling clock edge, so the master samples
	// a stable level while the clock is high.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff    <= ST_IDLE;
			bit_cnt_ff  <= 4'h0;
			shreg_ff    <= 8'h00;
			ptr_ff      <= 8'h00;
			read_ff     <= 1'b0;
			sda_drive_b <= 1'b1;
			wr_en_ff    <= 1'b0;
			wr_addr_ff  <= 8'h00;
			wr_data_ff  <= 8'h00;
		end else begin
			wr_en_ff <= 1'b0;
			if (bus_start) begin
				state_ff    <= ST_ADDR;
				bit_cnt_ff  <= 4'h0;
				sda_drive_b <= 1'b1;
			end else if (bus_stop) begin
				state_ff    <= ST_IDLE;
				sda_drive_b <= 1'b1;
			end else begin
				unique case (state_ff)
					ST_IDLE: begin
						sda_drive_b <= 1'b1;
					end
					ST_ADDR, ST_REG, ST_WDATA: begin
						if (scl_rise) begin
							shreg_ff   <= {shreg_ff[6:0], sda_s};
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end else if (scl_fall && bit_cnt_ff == BITS_PER_BYTE) begin
							bit_cnt_ff <= 4'h0;
							if (state_ff == ST_ADDR) begin
								if (shreg_ff[7:1] == dev_addr) begin
									read_ff     <= shreg_ff[0];
									sda_drive_b <= 1'b0;
									state_ff    <= ST_AACK;
								end else begin
									state_ff <= ST_IDLE;
								end
							end else if (state_ff == ST_REG) begin
								ptr_ff      <= shreg_ff;
								sda_drive_b <= 1'b0;
								state_ff    <= ST_DACK;
							end else begin
								wr_en_ff    <= 1'b1;
								wr_addr_ff  <= ptr_ff;
								wr_data_ff  <= shreg_ff;
								ptr_ff      <= ptr_ff + 8'h01;
								sda_drive_b <= 1'b0;
								state_ff    <= ST_DACK;
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							if (read_ff) begin
								shreg_ff    <= rd_data;
								sda_drive_b <= rd_data[7];
								bit_cnt_ff  <= 4'h1;
								ptr_ff      <= ptr_ff + 8'h01;
								state_ff    <= ST_RDATA;
							end else begin
								sda_drive_b <= 1'b1;
								state_ff    <= ST_REG;
							end
						end
					end
					ST_DACK: begin
						if (scl_fall) begin
							sda_drive_b <= 1'b1;
							state_ff    <= ST_WDATA;
						end
					end
					ST_RDATA: begin
						if (scl_fall) begin
							if (bit_cnt_ff == BITS_PER_BYTE) begin
								sda_drive_b <= 1'b1;
								bit_cnt_ff  <= 4'h0;
								state_ff    <= ST_RACK;
							end else begin
								shreg_ff    <= {shreg_ff[6:0], 1'b0};
								sda_drive_b <= shreg_ff[6];
								bit_cnt_ff  <= bit_cnt_ff + 4'h1;
							end
						end
					end
					ST_RACK: begin
						if (scl_rise && sda_s) begin
							state_ff <= ST_IDLE;
						end else if (scl_fall) begin
							shreg_ff    <= rd_data;
							sda_drive_b <= rd_data[7];
							bit_cnt_ff  <= 4'h1;
							ptr_ff      <= ptr_ff + 8'h01;
							state_ff    <= ST_RDATA;
						end
					end
				endcase
			end
		end
	end

	// The bus is open drain: only the enable ever moves.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// ========================================================================
	// Writable registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			retry_ctrl_ff <= RST_RETRY_CTRL;
			pdm_opt_ff    <= RST_PDM_OPT;
			boost_ctrl_ff <= RST_BOOST_CTRL;
		end else if (wr_en_ff) begin
			unique case (wr_addr_ff)
				ADDR_RETRY_CTRL: retry_ctrl_ff <= wr_data_ff & FC_WRITE_MASK;
				ADDR_PDM_OPT:    pdm_opt_ff    <= wr_data_ff;
				ADDR_BOOST_CTRL: boost_ctrl_ff <= wr_data_ff;
				default:         retry_ctrl_ff <= retry_ctrl_ff;
			endcase
		end
	end

	// ========================================================================
	// Manual recovery trigger
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			manual_trig_ff <= 1'b0;
		end else begin
			manual_trig_ff <= wr_en_ff && wr_addr_ff == ADDR_RETRY_CTRL &&
			                  wr_data_ff[FC_TRIG_BIT];
		end
	end

	// ========================================================================
	// Fault recovery engine
	function automatic logic [2:0] attempt_limit(input logic [1:0] code);
		unique case (code)
			LIMIT_ONE:   attempt_limit = ATTEMPTS_ONE;
			LIMIT_THREE: attempt_limit = ATTEMPTS_THREE;
			LIMIT_SEVEN: attempt_limit = ATTEMPTS_SEVEN;
			default:     attempt_limit = ATTEMPTS_SEVEN;
		endcase
	endfunction

	assign manual_mode = '{
		boost:       boost_ctrl_ff[BST_MODE_BIT],
		undervolt:   retry_ctrl_ff[FC_UV_BIT],
		overcurrent: retry_ctrl_ff[FC_OC_BIT],
		overheat:    retry_ctrl_ff[FC_OT_BIT]
	};

	// Each fault in auto mode waits a full gap after it appears before the first retry,
	// so a detector that has not settled is not hammered.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_FAULTS; i++) begin
				attempt_ff[i] <= 3'h0;
				gap_ff[i]     <= '0;
			end
			nxt_retry   <= '0;
			retry_pulse <= '0;
		end else begin
			retry_pulse <= nxt_retry;
			for (int i = 0; i < NUM_FAULTS; i++) begin
				nxt_retry[i] <= 1'b0;
				if (!fault_s[i]) begin
					attempt_ff[i] <= 3'h0;
					gap_ff[i]     <= GAP_W'(RETRY_GAP);
				end else if (manual_mode[i]) begin
					nxt_retry[i] <= manual_trig_ff;
				end else if (gap_ff[i] != '0) begin
					gap_ff[i] <= gap_ff[i] - GAP_W'(1);
				end else if (retry_ctrl_ff[FC_LIMIT_LSB +: 2] == LIMIT_UNLIMITED ||
				             attempt_ff[i] < attempt_limit(retry_ctrl_ff[FC_LIMIT_LSB +: 2])) begin
					nxt_retry[i] <= 1'b1;
					gap_ff[i]    <= GAP_W'(RETRY_GAP);
					if (attempt_ff[i] != ATTEMPTS_SEVEN) begin
						attempt_ff[i] <= attempt_ff[i] + 3'h1;
					end
				end
			end
		end
	end

	// ========================================================================
	// Gain and PDM option outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			warning_gain_cut <= 2'h0;
		end else begin
			warning_gain_cut <= warn_s ? retry_ctrl_ff[FC_GAIN_LSB +: 2] : 2'h0;
		end
	end

	// Options tied to one interface-select level read as off at the other.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pdm_cfg <= '0;
		end else begin
			pdm_cfg.channel_pick           <= if_sel_s & pdm_opt_ff[PDM_CHAN_BIT];
			pdm_cfg.pattern_command_enable <= ~if_sel_s & pdm_opt_ff[PDM_PAT_BIT];
			pdm_cfg.latency_mode           <= pdm_opt_ff[PDM_LAT_LSB +: 2];
			pdm_cfg.shared_bitclock        <= pdm_opt_ff[PDM_SHARE_BIT];
			pdm_cfg.sense_battery          <= pdm_mode_s & pdm_opt_ff[PDM_VBAT_BIT];
		end
	end

endmodule // afr_regs

// ===== core/afr_sync.sv
// Two-stage synchroniser for levels that arrive from outside the clock domain.
`timescale 1ns/1ns
module afr_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// ========================================================================
	// The first stage feeds only the second one.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= RST_VAL;
			q       <= RST_VAL;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule // afr_sync

// ===== sim/afr_host.sv
// Control-bus master model standing in for the host processor.
`timescale 1ns/1ns
module afr_host (
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_hi
);
	// ========================================================================
	// Bus phases
	// Each phase lasts 8 clocks, four times what the slave's synchronisers need.
	initial begin
		scl = 1'b1;
		sda_hi = 1'b1;
	end
	task automatic hold();
		repeat (8) @(negedge clk);
	endtask
	task automatic start();
		sda_hi = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sda_hi = 1'b0;
		hold();
		scl = 1'b0;
		hold();
	endtask
	task automatic stop();
		sda_hi = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sda_hi = 1'b1;
		hold();
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_hi = b;
		hold();
		scl = 1'b1;
		hold();
		r = sda_line;
		scl = 1'b0;
		hold();
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
			output logic nak);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(ack_in, nak);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] r, d, output logic ok);
		logic [7:0] q;
		logic       n0, n1;
		start();
		xfer({a, 1'b0}, 1'b1, q, n0);
		xfer(r, 1'b1, q, n1);
		xfer(d, 1'b1, q, n1);
		stop();
		ok = !n0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
			output logic ok);
		logic [7:0] q;
		logic       n0, n1;
		start();
		xfer({a, 1'b0}, 1'b1, q, n0);
		xfer(r, 1'b1, q, n1);
		start();
		xfer({a, 1'b1}, 1'b1, q, n1);
		xfer(8'hFF, 1'b1, d, n1);
		stop();
		ok = !n0;
	endtask
endmodule // afr_host

// ===== sim/afr_regs_monitor.sv
// Concurrent checks on the fault-recovery register bank ports.
`timescale 1ns/1ns
module afr_regs_monitor #(
	parameter int RETRY_GAP = 20
) (
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  scl_in,
	input wire logic                  sda_in,
	input wire logic                  sda_out,
	input wire logic                  sda_drive_b,
	input wire logic                  pdm_mode_pin,
	input wire logic                  if_select_pin,
	input wire logic                  channel_address_pin,
	input wire logic                  overheat_warn_in,
	input wire afr_pkg::afr_fault_t   fault_in,
	input wire afr_pkg::afr_fault_t   retry_pulse,
	input wire logic [1:0]            warning_gain_cut,
	input wire afr_pkg::afr_pdm_cfg_t pdm_cfg
);
	import afr_pkg::*;
	// ========================================================================
	// Properties
	// Pin windows cover two synchroniser flops plus the output register.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	retry_single_a: assert property (
		|retry_pulse |=> (retry_pulse & $past(retry_pulse)) == 4'h0)
		else $error("Retry pulse held longer than one cycle.");
	retry_spacing_a: assert property (
		retry_pulse.overheat |=> (!retry_pulse.overheat)[*8])
		else $error("Retry pulses too close together.");
	retry_needs_fault_a: assert property (
		(!fault_in.overcurrent)[*8] |-> !retry_pulse.overcurrent)
		else $error("Retry pulse without a fault present.");
	gain_idle_a: assert property (
		(!overheat_warn_in)[*6] |-> warning_gain_cut == 2'h0)
		else $error("Gain cut applied without a warning.");
	chan_gate_a: assert property (
		(!if_select_pin)[*5] |-> !pdm_cfg.channel_pick)
		else $error("Channel pick active with select pin low.");
	pattern_gate_a: assert property (
		if_select_pin[*5] |-> !pdm_cfg.pattern_command_enable)
		else $error("Pattern control active with select pin high.");
	sense_gate_a: assert property (
		(!pdm_mode_pin)[*5] |-> !pdm_cfg.sense_battery)
		else $error("Battery sense chosen outside PDM mode.");
	reset_cfg_a: assert property (
		$rose(rst_b) |-> ##4 (pdm_cfg == 6'h10 || if_select_pin))
		else $error("PDM options wrong after reset.");
endmodule // afr_regs_monitor

bind afr_regs afr_regs_monitor #(.RETRY_GAP(RETRY_GAP)) u_monitor (
	.clk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_drive_b, .pdm_mode_pin,
	.if_select_pin, .channel_address_pin, .overheat_warn_in, .fault_in,
	.retry_pulse, .warning_gain_cut, .pdm_cfg);

// ===== sim/test_amp_fault_recovery_pdm_config.sv
// Self-checking bench for the fault-recovery and PDM option registers.
`timescale 1ns/1ns
`define CHK(nm, e, v) begin n_checks++; if ((v) !== (e)) begin num_errors++; \
	$display("BAD %s expected %0h seen %0h", nm, e, v); end end
module test_amp_fault_recovery_pdm_config;
	import afr_pkg::*;
	// ========================================================================
	// Signals
	// A short retry gap keeps every auto-retry episode within a few hundred clocks.
	localparam int RETRY_SIM = 20;
	logic                clk, rst_b, scl, sda_hi, sda_out, sda_drive_b;
	logic                pdm_mode_pin, if_select_pin, channel_address_pin, overheat_warn_in;
	afr_fault_t          fault_in, retry_pulse;
	logic [1:0]          warning_gain_cut;
	afr_pdm_cfg_t        pdm_cfg;
	int                  num_errors, n_checks;
	int                  npul [4];
	int                  lim [3] = '{1, 3, 7};
	logic [7:0]          pv [3] = '{8'h9F, 8'h47, 8'h89};
	logic [1:0]          pp [3] = '{2'h3, 2'h0, 2'h2};
	logic [5:0]          pe [3] = '{6'h2F, 6'h16, 6'h09};
	wire                 sda_line = sda_hi & (sda_drive_b | sda_out);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++)
			if (retry_pulse[i] === 1'b1) npul[i]++;
	end
	afr_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_hi(sda_hi));
	afr_regs #(.RETRY_GAP(RETRY_SIM)) dut (.clk(clk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_drive_b(sda_drive_b),
		.pdm_mode_pin(pdm_mode_pin), .if_select_pin(if_select_pin),
		.channel_address_pin(channel_address_pin), .overheat_warn_in(overheat_warn_in),
		.fault_in(fault_in), .retry_pulse(retry_pulse),
		.warning_gain_cut(warning_gain_cut), .pdm_cfg(pdm_cfg));
	// ========================================================================
	// Tasks
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] r, d);
		logic k;
		u_host.wr(BUS_ADDR_FIXED, r, d, k);
	endtask
	task automatic rchk(input logic [7:0] r, e);
		logic [7:0] v;
		logic       k;
		u_host.rd(BUS_ADDR_FIXED, r, v, k);
		`CHK($sformatf("reg %0h", r), e, v)
	endtask
	task automatic ack(input logic [6:0] a, input logic e);
		logic [7:0] v;
		logic       k;
		u_host.rd(a, ADDR_PDM_OPT, v, k);
		`CHK("address ack", e, k)
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ========================================================================
	// Tests
	initial begin
		{rst_b, pdm_mode_pin, if_select_pin, channel_address_pin} = 4'h0;
		overheat_warn_in = 1'b0;
		fault_in = 4'h0;
		num_errors = 0;
		n_checks = 0;
		npul = '{default: 0};
		settle(4);
		rst_b = 1'b1;
		settle(4);
		rchk(ADDR_RETRY_CTRL, 8'h30);
		rchk(ADDR_PDM_OPT, 8'h40);
		rchk(ADDR_WARN_STATUS, 8'h00);
		rchk(8'h20, 8'h00);
		$display("test reset done");
		overheat_warn_in = 1'b1;
		for (int g = 0; g < 4; g++) begin
			wr(ADDR_RETRY_CTRL, {g[1:0], 6'h30});
			settle(8);
			`CHK("gain cut", g[1:0], warning_gain_cut)
		end
		rchk(ADDR_RETRY_CTRL, 8'hF0);
		rchk(ADDR_WARN_STATUS, 8'h01);
		overheat_warn_in = 1'b0;
		settle(8);
		`CHK("gain idle", 2'h0, warning_gain_cut)
		$display("test warning done");
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_RETRY_CTRL, {2'h0, c[1:0], 4'h0});
			npul = '{default: 0};
			fault_in = 4'hF;
			settle(256);
			for (int i = 0; i < 4; i++)
				`CHK("auto tries", 1'b1, (c == 3) ? npul[i] > 7 : npul[i] == lim[c])
			fault_in = 4'h0;
			settle(12);
		end
		$display("test auto retry done");
		wr(ADDR_BOOST_CTRL, 8'h08);
		wr(ADDR_RETRY_CTRL, 8'h37);
		rchk(ADDR_BOOST_CTRL, 8'h08);
		npul = '{default: 0};
		fault_in = 4'hF;
		settle(256);
		rchk(ADDR_FAULT_STATUS, 8'h8E);
		wr(ADDR_RETRY_CTRL, 8'h3F);
		settle(16);
		for (int i = 0; i < 4; i++)
			`CHK("manual tries", 1, npul[i])
		rchk(ADDR_RETRY_CTRL, 8'h37);
		// Mixed modes show that each mode bit steers only its own fault.
		npul = '{default: 0};
		wr(ADDR_RETRY_CTRL, 8'h3A);
		settle(64);
		for (int i = 0; i < 4; i++)
			`CHK("mixed tries", 1'b1, i % 3 == 0 ? npul[i] == 1 : npul[i] > 1)
		fault_in = 4'h5;
		rchk(ADDR_FAULT_STATUS, 8'h0A);
		fault_in = 4'h0;
		$display("test manual retry done");
		for (int k = 0; k < 3; k++) begin
			{pdm_mode_pin, if_select_pin} = pp[k];
			wr(ADDR_PDM_OPT, pv[k]);
			settle(8);
			`CHK("pdm cfg", pe[k], pdm_cfg)
			rchk(ADDR_PDM_OPT, pv[k]);
		end
		$display("test pdm options done");
		channel_address_pin = 1'b1;
		ack(BUS_ADDR_ALT, 1'b0);
		wr(ADDR_PDM_OPT, 8'h99);
		ack(BUS_ADDR_FIXED, 1'b0);
		ack(BUS_ADDR_ALT, 1'b1);
		channel_address_pin = 1'b0;
		ack(BUS_ADDR_FIXED, 1'b1);
		$display("test address done");
		summarize();
	end
endmodule // test_amp_fault_recovery_pdm_config
